// [logic/parallel_display_defs.vh]
// Constants for the parallel display host port: indexes, fields, reset values, timing
`ifndef PARALLEL_DISPLAY_DEFS_VH
`define PARALLEL_DISPLAY_DEFS_VH

// Index values written with the select low
`define IDX_BACKLIGHT      16'h0001
`define IDX_START_ROW      16'h0002
`define IDX_START_COL      16'h0003
`define IDX_SHOWN_PAGE     16'h0004
`define IDX_ACCESS_PAGE    16'h0005
`define IDX_END_ROW        16'h0006
`define IDX_END_COL        16'h0007
`define IDX_SLEEP          16'h000B
`define IDX_ORIENT         16'h000C
`define IDX_INC_DIR        16'h000D
`define IDX_PIXEL          16'h000F

// Field positions and values
`define BL_MAX             16'h0010
`define SLEEP_ENTER        16'h0001
`define INC_DIR_COLUMN     16'h0001
`define ORIENT_FLIP_V_BIT  0
`define ORIENT_MIRROR_BIT  1
`define ORIENT_MODE_HI     3
`define ORIENT_MODE_LO     2
`define ORIENT_MODE_TEST   2'h2
`define PAGE_MAX           16'h0007

// Reset values
`define RST_INDEX          16'h0000
`define RST_BACKLIGHT      5'h00
`define RST_PAGE           3'h0
`define RST_START_ROW      9'h000
`define RST_START_COL      10'h000
`define RST_END_ROW        9'h1DF
`define RST_END_COL        10'h31F
`define RST_ORIENT         4'h0

// Panel geometry and video memory
`define PANEL_ROWS         9'h1E0
`define PANEL_COLS         10'h320
`define LAST_ROW           9'h1DF
`define LAST_COL           10'h31F
`define PAGE_WORDS         22'h05DC00
`define ROW_WORDS          22'h000320
`define VMEM_DEPTH         22'h2EE000
`define SELF_TEST_BAR      10'h064

// Backlight timing: PWM frequency in Hz, sixteen duty steps per period
`define CLK_HZ             50000000
`define BL_PWM_HZ          300
`define BL_STEPS           16
// Clock over PWM rate times steps, rounded down, sized for the 16-bit divider
`define BL_STEP_CYCLES     16'h28B0

`endif

// [logic/parallel_display_host_port.v]
// Host port of a paged display: 8080 bus, control registers, backlight and scan-out
// How it works
// - Index 0x0001 then data loads backlight level 0..16; resets to 0.
// - Level 0 is off, 16 full on, between proportional duty.
// - Index 0x0002 then data loads 9-bit window first row.
// - Index 0x0003 then data loads 10-bit window first column.
// - Index 0x0006 then data loads 9-bit window last row.
// - Index 0x0007 then data loads 10-bit window last column.
// - Index 0x0004 then data picks the shown page; page 0 after reset.
// - Index 0x0005 then data picks the host access page; page 0 after reset.
// - Shown page and access page are separate registers.
// - Eight full pages of 800 by 480 pixels are held.
// - Index 0x000B then data 0x0001 enters sleep.
// - Any read or write strobe falling with select low wakes the block from sleep, unless sleep is entered in that cycle.
// - Orientation bit 0 flips the shown page vertically, bit 1 mirrors it horizontally; the self-test bars are not mirrored.
// - Orientation bits 3:2 at 0 is normal, at 2 is self-test pattern.
// - Index 0x000D: 0 steps along rows, 1 steps along columns.
// - Index 0x000F then each data write stores one pixel at the cursor.
// - Select low, write high, read low drives memory word onto the bus.
// - Bus cycles of 200 ns back to back lose no data.
// - Write with select low is an index, select high is data.
// - Pixel accesses advance by one and wrap at the window's last column, or at its last row when stepping along columns.
// - Brightness writes above 16 are ignored.
// - Pixel words are RGB565: red 15:11, green 10:5, blue 4:0.
`timescale 1ns/1ns
`include "parallel_display_defs.vh"

module parallel_display_host_port #(
    parameter [15:0] BL_STEP_CYCLES = `BL_STEP_CYCLES
) (
    core_clk,
    reset,
    cs_n,
    index_or_data_select,
    wr_n,
    rd_n,
    data_in,
    data_out,
    data_oe_n,
    backlight_pwm,
    sleep_active,
    scan_red,
    scan_green,
    scan_blue,
    scan_frame_start
);
    input  wire        core_clk;
    input  wire        reset;
    input  wire        cs_n;
    input  wire        index_or_data_select;
    input  wire        wr_n;
    input  wire        rd_n;
    input  wire [15:0] data_in;
    output reg  [15:0] data_out;
    output reg         data_oe_n;
    output reg         backlight_pwm;
    output reg         sleep_active;
    output reg  [4:0]  scan_red;
    output reg  [5:0]  scan_green;
    output reg  [4:0]  scan_blue;
    output reg         scan_frame_start;

    // Linear word address of a pixel: page, row, column
    function [21:0] pix_addr;
        input [2:0] page;
        input [8:0] row;
        input [9:0] col;
        begin
            pix_addr = ({19'h00000, page} * `PAGE_WORDS)
                     + ({13'h0000, row} * `ROW_WORDS)
                     + {12'h000, col};
        end
    endfunction

    // Self-test colour bars, eight bars of 100 columns each
    function [15:0] test_bar;
        input [9:0] col;
        reg   [2:0] bar;
        begin
            bar = 3'h0;
            if (col >= 10'h2BC) begin
                bar = 3'h7;
            end else if (col >= 10'h258) begin
                bar = 3'h6;
            end else if (col >= 10'h1F4) begin
                bar = 3'h5;
            end else if (col >= 10'h190) begin
                bar = 3'h4;
            end else if (col >= 10'h12C) begin
                bar = 3'h3;
            end else if (col >= 10'h0C8) begin
                bar = 3'h2;
            end else if (col >= `SELF_TEST_BAR) begin
                bar = 3'h1;
            end
            test_bar = {{5{bar[2]}}, {6{bar[1]}}, {5{bar[0]}}};
        end
    endfunction

    // Bus inputs of the previous cycle, for strobe edge detection
    reg        cs_n_q;
    reg        wr_n_q;
    reg        rd_n_q;
    reg        sel_q;
    reg [15:0] data_q;

    // Control registers
    reg [15:0] index_r;
    reg [4:0]  backlight_r;
    reg [8:0]  start_row_r;
    reg [9:0]  start_col_r;
    reg [8:0]  end_row_r;
    reg [9:0]  end_col_r;
    reg [2:0]  shown_page_r;
    reg [2:0]  access_page_r;
    reg [3:0]  orient_r;
    reg        col_dir_r;
    reg        sleep_r;
    reg [8:0]  cur_row_r;
    reg [9:0]  cur_col_r;

    // Cursor step and bus events
    reg  [8:0]  cur_row_nxt;
    reg  [9:0]  cur_col_nxt;
    wire        wr_done;
    wire        rd_done;
    wire        acc_start;
    wire        data_wr;
    wire        host_we;
    wire [21:0] host_addr;
    wire [15:0] host_rdata;
    wire        reading;

    // chip select gating
    // A strobe counts only if select was low in the last cycle before the strobe rose
    assign wr_done   = !cs_n_q && !wr_n_q && wr_n;
    assign rd_done   = !cs_n_q && !rd_n_q && rd_n && wr_n_q;
    assign acc_start = !cs_n && ((!wr_n && wr_n_q) || (!rd_n && rd_n_q));
    assign data_wr   = wr_done && sel_q;
    assign host_we   = data_wr && (index_r == `IDX_PIXEL);
    assign host_addr = pix_addr(access_page_r, cur_row_r, cur_col_r);
    assign reading   = !cs_n && wr_n && !rd_n;

    // Sample bus pins; data is taken while the strobe is still low
    always @(posedge core_clk) begin
        if (reset) begin
            cs_n_q <= 1'b1;
            wr_n_q <= 1'b1;
            rd_n_q <= 1'b1;
            sel_q  <= 1'b0;
            data_q <= 16'h0000;
        end else begin
            cs_n_q <= cs_n;
            wr_n_q <= wr_n;
            rd_n_q <= rd_n;
            if (!wr_n) begin
                sel_q  <= index_or_data_select;
                data_q <= data_in;
            end
        end
    end

    always @* begin
        cur_row_nxt = cur_row_r;
        cur_col_nxt = cur_col_r;
        if (!col_dir_r) begin
            if (cur_col_r >= end_col_r) begin
                cur_col_nxt = start_col_r;
                if (cur_row_r >= end_row_r) begin
                    cur_row_nxt = start_row_r;
                end else begin
                    cur_row_nxt = cur_row_r + 9'h001;
                end
            end else begin
                cur_col_nxt = cur_col_r + 10'h001;
            end
        end else begin
            if (cur_row_r >= end_row_r) begin
                cur_row_nxt = start_row_r;
                if (cur_col_r >= end_col_r) begin
                    cur_col_nxt = start_col_r;
                end else begin
                    cur_col_nxt = cur_col_r + 10'h001;
                end
            end else begin
                cur_row_nxt = cur_row_r + 9'h001;
            end
        end
    end

    // Register writes and cursor; every write lands a 200 ns cycle with room to spare
    always @(posedge core_clk) begin
        if (reset) begin
            index_r       <= `RST_INDEX;
            backlight_r   <= `RST_BACKLIGHT;
            start_row_r   <= `RST_START_ROW;
            start_col_r   <= `RST_START_COL;
            end_row_r     <= `RST_END_ROW;
            end_col_r     <= `RST_END_COL;
            shown_page_r  <= `RST_PAGE;
            access_page_r <= `RST_PAGE;
            orient_r      <= `RST_ORIENT;
            col_dir_r     <= 1'b0;
            cur_row_r     <= `RST_START_ROW;
            cur_col_r     <= `RST_START_COL;
        end else begin
            if (wr_done && !sel_q) begin
                index_r <= data_q;
            end
            if (host_we || rd_done) begin
                cur_row_r <= cur_row_nxt;
                cur_col_r <= cur_col_nxt;
            end
            if (data_wr) begin
                if (index_r == `IDX_BACKLIGHT) begin
                    if (data_q <= `BL_MAX) begin
                        backlight_r <= data_q[4:0];
                    end
                end else if (index_r == `IDX_START_ROW) begin
                    start_row_r <= data_q[8:0];
                    cur_row_r   <= data_q[8:0];
                end else if (index_r == `IDX_START_COL) begin
                    start_col_r <= data_q[9:0];
                    cur_col_r   <= data_q[9:0];
                end else if (index_r == `IDX_END_ROW) begin
                    end_row_r <= data_q[8:0];
                end else if (index_r == `IDX_END_COL) begin
                    end_col_r <= data_q[9:0];
                end else if (index_r == `IDX_SHOWN_PAGE) begin
                    if (data_q <= `PAGE_MAX) begin
                        shown_page_r <= data_q[2:0];
                    end
                end else if (index_r == `IDX_ACCESS_PAGE) begin
                    if (data_q <= `PAGE_MAX) begin
                        access_page_r <= data_q[2:0];
                    end
                end else if (index_r == `IDX_ORIENT) begin
                    orient_r <= data_q[3:0];
                end else if (index_r == `IDX_INC_DIR) begin
                    col_dir_r <= (data_q == `INC_DIR_COLUMN);
                end
            end
        end
    end

    // Sleep: entering wins over a wake seen in the same cycle
    always @(posedge core_clk) begin
        if (reset) begin
            sleep_r <= 1'b0;
        end else if (data_wr && (index_r == `IDX_SLEEP) && (data_q == `SLEEP_ENTER)) begin
            sleep_r <= 1'b1;
        end else if (acc_start) begin
            sleep_r <= 1'b0;
        end
    end

    // Bus drive: data follows memory by two cycles, well inside a read strobe
    always @(posedge core_clk) begin
        if (reset) begin
            data_out     <= 16'h0000;
            data_oe_n    <= 1'b1;
            sleep_active <= 1'b0;
        end else begin
            data_oe_n    <= !reading;
            data_out     <= host_rdata;
            sleep_active <= sleep_r;
        end
    end

    // Backlight PWM: sixteen steps per period, level counts lit steps
    reg [15:0] bl_div_r;
    reg [3:0]  bl_phase_r;

    always @(posedge core_clk) begin
        if (reset) begin
            bl_div_r      <= 16'h0000;
            bl_phase_r    <= 4'h0;
            backlight_pwm <= 1'b0;
        end else begin
            if (bl_div_r >= BL_STEP_CYCLES - 16'h0001) begin
                bl_div_r   <= 16'h0000;
                bl_phase_r <= bl_phase_r + 4'h1;
            end else begin
                bl_div_r <= bl_div_r + 16'h0001;
            end
            backlight_pwm <= !sleep_r && ({1'b0, bl_phase_r} < backlight_r);
        end
    end

    // Scan-out raster over the shown page
    reg  [8:0]  scan_row_r;
    reg  [9:0]  scan_col_r;
    reg  [9:0]  scan_col_d_r;
    reg         scan_first_d_r;
    wire [8:0]  src_row;
    wire [9:0]  src_col;
    wire [21:0] scan_addr;
    wire [15:0] scan_rdata;
    reg  [15:0] scan_word;

    assign src_row   = orient_r[`ORIENT_FLIP_V_BIT] ? (`LAST_ROW - scan_row_r) : scan_row_r;
    assign src_col   = orient_r[`ORIENT_MIRROR_BIT] ? (`LAST_COL - scan_col_r) : scan_col_r;
    assign scan_addr = pix_addr(shown_page_r, src_row, src_col);

    // Raster counters, one pixel per clock
    always @(posedge core_clk) begin
        if (reset) begin
            scan_row_r     <= 9'h000;
            scan_col_r     <= 10'h000;
            scan_col_d_r   <= 10'h000;
            scan_first_d_r <= 1'b0;
        end else begin
            scan_col_d_r   <= scan_col_r;
            scan_first_d_r <= (scan_row_r == 9'h000) && (scan_col_r == 10'h000);
            if (scan_col_r == `LAST_COL) begin
                scan_col_r <= 10'h000;
                if (scan_row_r == `LAST_ROW) begin
                    scan_row_r <= 9'h000;
                end else begin
                    scan_row_r <= scan_row_r + 9'h001;
                end
            end else begin
                scan_col_r <= scan_col_r + 10'h001;
            end
        end
    end

    always @* begin
        if (orient_r[`ORIENT_MODE_HI:`ORIENT_MODE_LO] == `ORIENT_MODE_TEST) begin
            scan_word = test_bar(scan_col_d_r);
        end else begin
            scan_word = scan_rdata;
        end
    end

    always @(posedge core_clk) begin
        if (reset) begin
            scan_red         <= 5'h00;
            scan_green       <= 6'h00;
            scan_blue        <= 5'h00;
            scan_frame_start <= 1'b0;
        end else begin
            scan_red         <= scan_word[15:11];
            scan_green       <= scan_word[10:5];
            scan_blue        <= scan_word[4:0];
            scan_frame_start <= scan_first_d_r;
        end
    end

    video_memory u_video_memory (
        .core_clk   (core_clk),
        .host_we    (host_we),
        .host_addr  (host_addr),
        .host_wdata (data_q),
        .host_rdata (host_rdata),
        .scan_addr  (scan_addr),
        .scan_rdata (scan_rdata)
    );

endmodule // parallel_display_host_port

// [logic/video_memory.v]
// Paged video memory: one host read/write port and one scan-out read port
`timescale 1ns/1ns
`include "parallel_display_defs.vh"

module video_memory (
    core_clk,
    host_we,
    host_addr,
    host_wdata,
    host_rdata,
    scan_addr,
    scan_rdata
);
    input  wire        core_clk;
    input  wire        host_we;
    input  wire [21:0] host_addr;
    input  wire [15:0] host_wdata;
    output reg  [15:0] host_rdata;
    input  wire [21:0] scan_addr;
    output reg  [15:0] scan_rdata;

    // Eight pages of 800 by 480 words
    reg [15:0] mem [0:`VMEM_DEPTH-1];

    // Host port, read data registered; addresses past the end are dropped
    always @(posedge core_clk) begin
        if (host_we && (host_addr < `VMEM_DEPTH)) begin
            mem[host_addr] <= host_wdata;
        end
        if (host_addr < `VMEM_DEPTH) begin
            host_rdata <= mem[host_addr];
        end else begin
            host_rdata <= 16'h0000;
        end
    end

    // Scan port, read only
    always @(posedge core_clk) begin
        if (scan_addr < `VMEM_DEPTH) begin
            scan_rdata <= mem[scan_addr];
        end else begin
            scan_rdata <= 16'h0000;
        end
    end

endmodule // video_memory

// [tb/display_port_checker_asserts.sv]
// Concurrent checks on the display host port pins
`timescale 1ns/1ns
`include "parallel_display_defs.vh"

module display_port_checker (
    input wire        core_clk,
    input wire        reset,
    input wire        cs_n,
    input wire        index_or_data_select,
    input wire        wr_n,
    input wire        rd_n,
    input wire [15:0] data_in,
    input wire        data_oe_n,
    input wire        backlight_pwm,
    input wire        sleep_active,
    input wire        scan_frame_start
);
    reg        wr_low_r;
    reg        cs_low_r;
    reg        sel_r;
    reg [15:0] din_r;
    reg [15:0] idx_r;
    wire       take = wr_n && wr_low_r && cs_low_r;

    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);

    // Shadow decode of the bus; a write is taken as the strobe rises
    always @(posedge core_clk) begin
        wr_low_r <= !wr_n;
        cs_low_r <= !cs_n;
        sel_r    <= index_or_data_select;
        din_r    <= data_in;
        if (reset)
            idx_r <= `RST_INDEX;
        else if (take && !sel_r)
            idx_r <= din_r;
    end

    property p_idle_release;
        cs_n && $past(cs_n) |-> data_oe_n;
    endproperty
    a_idle_release: assert property (p_idle_release)
        else $error("bus driven while deselected");

    property p_rd_release;
        rd_n && $past(rd_n) |-> data_oe_n;
    endproperty
    a_rd_release: assert property (p_rd_release)
        else $error("bus driven without read strobe");

    property p_read_drive;
        (!cs_n && wr_n && !rd_n) [*2] |=> !data_oe_n;
    endproperty
    a_read_drive: assert property (p_read_drive)
        else $error("read strobe not answered");

    property p_bl_reset;
        $fell(reset) |-> !backlight_pwm [*8];
    endproperty
    a_bl_reset: assert property (p_bl_reset)
        else $error("backlight lit after reset");

    property p_sleep_enter;
        take && sel_r && idx_r == `IDX_SLEEP && din_r == `SLEEP_ENTER |-> ##[1:3] sleep_active;
    endproperty
    a_sleep_enter: assert property (p_sleep_enter)
        else $error("sleep command not obeyed");

    property p_sleep_wake;
        sleep_active && !cs_n && ($fell(rd_n) || $fell(wr_n)) |-> ##[1:3] !sleep_active;
    endproperty
    a_sleep_wake: assert property (p_sleep_wake)
        else $error("bus access did not wake");

    property p_sleep_dark;
        sleep_active && $past(sleep_active) |-> !backlight_pwm;
    endproperty
    a_sleep_dark: assert property (p_sleep_dark)
        else $error("backlight lit while asleep");

    property p_frame_pulse;
        scan_frame_start |=> !scan_frame_start;
    endproperty
    a_frame_pulse: assert property (p_frame_pulse)
        else $error("frame start longer than one pixel");
endmodule // display_port_checker

bind parallel_display_host_port display_port_checker checker_u (
    .core_clk             (core_clk),
    .reset                (reset),
    .cs_n                 (cs_n),
    .index_or_data_select (index_or_data_select),
    .wr_n                 (wr_n),
    .rd_n                 (rd_n),
    .data_in              (data_in),
    .data_oe_n            (data_oe_n),
    .backlight_pwm        (backlight_pwm),
    .sleep_active         (sleep_active),
    .scan_frame_start     (scan_frame_start)
);

// [tb/host_model.sv]
// Behavioural host processor on the 8080 bus
`timescale 1ns/1ns

module host_model (
    input  wire         core_clk,
    input  wire  [15:0] bus_in,
    output logic        cs_n,
    output logic        sel,
    output logic        wr_n,
    output logic        rd_n,
    output logic [15:0] bus_drive
);
    // Idle bus, strobes high
    initial begin
        cs_n = 1'b1;
        sel = 1'b1;
        wr_n = 1'b1;
        rd_n = 1'b1;
        bus_drive = 16'hA5A5;
    end

    task automatic put(input logic s, input logic [15:0] d, input logic en);
        @(posedge core_clk);
        cs_n <= !en;
        sel <= s;
        bus_drive <= d;
        wr_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        wr_n <= 1'b1;
        @(posedge core_clk);
        cs_n <= 1'b1;
        bus_drive <= ~d; // Released: never leave the old value standing
        repeat (5) @(posedge core_clk);
    endtask

    task automatic wr(input logic [15:0] idx, input logic [15:0] val);
        put(1'b0, idx, 1'b1);
        put(1'b1, val, 1'b1);
    endtask

    // read sampled late, after the word settles
    task automatic get(output logic [15:0] d, input logic en);
        @(posedge core_clk);
        cs_n <= !en;
        rd_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        d = bus_in;
        rd_n <= 1'b1;
        @(posedge core_clk);
        cs_n <= 1'b1;
        repeat (4) @(posedge core_clk);
    endtask
endmodule // host_model

// [tb/parallel_display_host_port_bench.sv]
// Self-checking bench for the parallel display host port
`timescale 1ns/1ns
`include "parallel_display_defs.vh"

module parallel_display_host_port_bench;
    typedef struct { logic [15:0] lvl; int duty; } bl_row_t;
    logic        core_clk = 1'b0;
    logic        reset = 1'b1;
    wire         cs_n, sel, wr_n, rd_n;
    wire  [15:0] host_drive, bus, data_out;
    wire         data_oe_n, backlight_pwm, sleep_active, scan_frame_start;
    wire  [4:0]  scan_red, scan_blue;
    wire  [5:0]  scan_green;
    int          n_mismatch = 0;
    int          checks = 0;
    int          n, k;
    logic [15:0] d;
    // Duty over one 64-clock period; 17 is refused so 16 stays
    bl_row_t     rows [5] = '{'{16'h0000, 0}, '{16'h0001, 4}, '{16'h0008, 32},
                              '{16'h0010, 64}, '{16'h0011, 64}};
    logic [15:0] pix [4] = '{16'hF800, 16'h07E0, 16'h001F, 16'hFFFF};
    int          ord [4] = '{0, 2, 1, 3};

    // Bus level: device drives only with its enable low
    assign bus = data_oe_n ? host_drive : data_out;

    // 50 MHz clock
    always #10 core_clk = ~core_clk;

    parallel_display_host_port #(.BL_STEP_CYCLES(16'h0004)) dut_u (
        .core_clk (core_clk), .reset (reset), .cs_n (cs_n),
        .index_or_data_select (sel), .wr_n (wr_n), .rd_n (rd_n),
        .data_in (bus), .data_out (data_out), .data_oe_n (data_oe_n),
        .backlight_pwm (backlight_pwm), .sleep_active (sleep_active),
        .scan_red (scan_red), .scan_green (scan_green), .scan_blue (scan_blue),
        .scan_frame_start (scan_frame_start)
    );

    host_model host_u (
        .core_clk (core_clk), .bus_in (bus), .cs_n (cs_n), .sel (sel),
        .wr_n (wr_n), .rd_n (rd_n), .bus_drive (host_drive)
    );

    task automatic fail(input string msg);
        n_mismatch++;
        $display("CHECK FAILED %0t %s", $time, msg);
    endtask

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) fail($sformatf("word %h expected %h", got, exp));
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) fail($sformatf("flag %b expected %b", got, exp));
    endtask

    task automatic chk_count(input int got, input int exp);
        checks++;
        if (got != exp) fail($sformatf("count %0d expected %0d", got, exp));
    endtask

    // Counts lit clocks over one full period, whatever its phase
    task automatic bl_count(output int cnt);
        cnt = 0;
        repeat (64) begin
            @(negedge core_clk);
            cnt += (backlight_pwm === 1'b1);
        end
    endtask

    // Writing the start corner also moves the cursor there
    task automatic home();
        host_u.wr(`IDX_START_ROW, 16'h0002);
        host_u.wr(`IDX_START_COL, 16'h031E);
        host_u.put(1'b0, `IDX_PIXEL, 1'b1);
    endtask

    // Self-test bars: each field all ones or all zeros, all eight bars seen
    task automatic bar_scan(output int seen, output int bad);
        seen = 0;
        bad = 0;
        repeat (800) begin
            @(negedge core_clk);
            seen |= 1 << {scan_red[0], scan_green[0], scan_blue[0]};
            bad += (scan_red !== {5{scan_red[0]}}) || (scan_green !== {6{scan_green[0]}})
                   || (scan_blue !== {5{scan_blue[0]}});
        end
    endtask

    // three clocks of reset stand in for the host's 1 ms
    task automatic release_reset();
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        @(negedge core_clk);
        chk_bit(data_oe_n, 1'b1);
        chk_bit(sleep_active, 1'b0);
        repeat (2) @(negedge core_clk);
        chk_bit(scan_frame_start, 1'b1);
        bl_count(n);
        chk_count(n, 0);
    endtask

    task automatic report_and_stop();
        if (n_mismatch == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Hang guard, well beyond the few thousand clocks needed
    initial begin
        #400000;
        n_mismatch++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        release_reset();
        foreach (rows[i]) begin
            host_u.wr(`IDX_BACKLIGHT, rows[i].lvl);
            bl_count(n);
            chk_count(n, rows[i].duty);
        end
        // Two-by-two window in the last columns, filled along rows
        host_u.wr(`IDX_END_ROW, 16'h0003);
        host_u.wr(`IDX_END_COL, 16'h031F);
        host_u.wr(`IDX_ACCESS_PAGE, 16'h0001);
        home();
        foreach (pix[i]) host_u.put(1'b1, pix[i], 1'b1);
        // Read back along columns: order exposes the row wrap
        host_u.wr(`IDX_INC_DIR, `INC_DIR_COLUMN);
        home();
        foreach (ord[i]) begin
            host_u.get(d, 1'b1);
            chk_word(d, pix[ord[i]]);
        end
        // Other page written, first page untouched
        host_u.wr(`IDX_ACCESS_PAGE, 16'h0000);
        home();
        host_u.put(1'b1, 16'h1234, 1'b1);
        host_u.wr(`IDX_SHOWN_PAGE, 16'h0001);
        host_u.wr(`IDX_ACCESS_PAGE, 16'h0001);
        home();
        host_u.get(d, 1'b1);
        chk_word(d, pix[0]);
        // Sleep darkens the lamp, a read wakes it
        host_u.wr(`IDX_SLEEP, `SLEEP_ENTER);
        bl_count(n);
        chk_bit(sleep_active, 1'b1);
        chk_count(n, 0);
        host_u.get(d, 1'b1);
        @(negedge core_clk);
        chk_bit(sleep_active, 1'b0);
        // Deselected strobes must not reach the level
        host_u.wr(`IDX_BACKLIGHT, 16'h0008);
        host_u.put(1'b1, 16'h0000, 1'b0);
        host_u.get(d, 1'b0);
        bl_count(n);
        chk_count(n, 32);
        // Self-test pattern replaces memory on the scan pins
        host_u.wr(`IDX_ORIENT, 16'h0008);
        bar_scan(n, k);
        chk_count(n, 255);
        chk_count(k, 0);
        // Mid-run reset: defaults return, page 0 content survives
        @(posedge core_clk);
        reset <= 1'b1;
        release_reset();
        home();
        host_u.get(d, 1'b1);
        chk_word(d, 16'h1234);
        report_and_stop();
    end
endmodule // parallel_display_host_port_bench
